/* File: ipc_port_flags.sv */
// Serial port control register one with collision and overflow flags, active status,
// transfer buffer and a small receive queue, reached over AXI4-Lite.
// Assumes the shift and bus sequencer runs on aclk and pulses seq_done when a sequence ends.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

module ipc_port_flags #(
  parameter int FIFO_DEPTH = 2,
  parameter int DATA_W     = 8
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [ipc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                awprot,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [ipc_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                arprot,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire ipc_pkg::ipc_mode_s        port_mode,
  input  wire logic                      tx_in_progress,
  input  wire logic                      start_allowed,
  input  wire logic                      tx_shifting,
  input  wire logic [ipc_pkg::SEQ_W-1:0] seq_done,
  input  wire logic [DATA_W-1:0]         rx_data,
  input  wire logic                      rx_valid,
  output logic                           rx_ready,
  output logic [DATA_W-1:0]              tx_data,
  output logic                           tx_load,
  output ipc_pkg::ipc_ctl_s              ctl_out,
  output logic [ipc_pkg::SEQ_W-1:0]      seq_enable,
  output logic                           port_active
);
  import ipc_pkg::*;

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = CNT_W'(FIFO_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE       = CNT_W'(1);

  // Bus slave state
  logic                       aw_have_reg, aw_have_next;
  logic [ADDR_W-1:0]          aw_addr_reg, aw_addr_next;
  logic                       w_have_reg, w_have_next;
  logic [31:0]                w_data_reg, w_data_next;
  logic [3:0]                 w_strb_reg, w_strb_next;
  logic                       awready_reg, awready_next;
  logic                       wready_reg, wready_next;
  logic                       bvalid_reg, bvalid_next;
  logic [1:0]                 bresp_reg, bresp_next;
  logic                       arready_reg, arready_next;
  logic                       rvalid_reg, rvalid_next;
  logic [1:0]                 rresp_reg, rresp_next;
  logic [31:0]                rdata_reg, rdata_next;

  // Register file state
  ipc_ctl_s                   ctl_reg, ctl_next;
  logic [SEQ_W-1:0]           seq_reg, seq_next;
  logic                       active_reg, active_next;
  logic [DATA_W-1:0]          rx_buf_reg, rx_buf_next;
  logic                       buf_full_reg, buf_full_next;
  logic [DATA_W-1:0]          tx_data_reg, tx_data_next;
  logic                       tx_load_reg, tx_load_next;

  // Receive queue state
  logic [DATA_W-1:0]          fifo_mem [FIFO_DEPTH];
  logic [DATA_W-1:0]          fifo_wdata;
  logic [PTR_W-1:0]           wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0]           rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0]           count_reg, count_next;
  logic                       rx_ready_reg, rx_ready_next;

  // Events shared between groups
  logic                       wr_fire;
  logic                       rd_fire;
  logic                       rx_fire;
  logic                       overflow_hit;
  logic                       fifo_push;
  logic                       fifo_pop;
  logic                       collision_hit;
  logic                       buf_wr;
  logic                       buf_rd;
  logic                       ctl_wr;
  logic                       seq_wr;
  logic                       map_err_w;
  logic                       map_err_r;

  // Wraps a queue pointer at the configured depth
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(FIFO_DEPTH - 1)) begin
      return '0;
    end else begin
      return PTR_W'(p + PTR_W'(1));
    end
  endfunction

  // True for any of the four mapped offsets
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    if (a == OFF_CTL) begin
      return 1'b1;
    end else if (a == OFF_SEQ) begin
      return 1'b1;
    end else if (a == OFF_BUF) begin
      return 1'b1;
    end else if (a == OFF_STAT) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // Write performed once both halves are held and no response is pending
  assign wr_fire   = aw_have_reg && w_have_reg && !bvalid_reg;
  assign rd_fire   = arvalid && arready_reg;
  assign map_err_w = !is_mapped(aw_addr_reg);
  assign map_err_r = !is_mapped(araddr);
  assign ctl_wr    = wr_fire && (aw_addr_reg == OFF_CTL) && w_strb_reg[0];
  assign seq_wr    = wr_fire && (aw_addr_reg == OFF_SEQ) && w_strb_reg[0];
  assign buf_wr    = wr_fire && (aw_addr_reg == OFF_BUF) && w_strb_reg[0];
  assign buf_rd    = rd_fire && (araddr == OFF_BUF) && !port_mode.transmit_mode;

  // Bus slave next state; address and data taken in either order
  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready_reg) begin
      w_have_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = map_err_w ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = map_err_r ? RESP_SLVERR : RESP_OKAY;
      rdata_next  = '0;
      if (araddr == OFF_CTL) begin
        rdata_next[7:0] = ctl_reg;
      end else if (araddr == OFF_SEQ) begin
        rdata_next[SEQ_W-1:0] = seq_reg;
      end else if (araddr == OFF_BUF) begin
        rdata_next[DATA_W-1:0] = port_mode.transmit_mode ? tx_data_reg : rx_buf_reg;
      end else if (araddr == OFF_STAT) begin
        rdata_next[STAT_ACTIVE] = active_reg;
        rdata_next[STAT_FULL]   = buf_full_reg;
      end
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    // Ready only while the holding slot is free, so outputs stay registered
    awready_next = !aw_have_next;
    wready_next  = !w_have_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end else begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg  <= w_have_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Pop only into an empty buffer, after this cycle's read has freed it
  function automatic logic buf_full_next_block();
    return buf_full_reg && !buf_rd;
  endfunction

  // Receive path events; bytes seen while transmitting are dropped unflagged
  assign rx_fire      = rx_valid && rx_ready_reg;
  assign overflow_hit = rx_fire && !port_mode.transmit_mode && buf_full_reg;
  assign fifo_push    = rx_fire && !port_mode.transmit_mode && !buf_full_reg;
  assign fifo_pop     = (count_reg != '0) && !buf_full_next_block();
  assign fifo_wdata   = rx_data;

  // Transmit side collision: master needs a startable bus, slave an idle shifter
  assign collision_hit = buf_wr && port_mode.transmit_mode &&
                         ((port_mode.master_mode && !start_allowed) ||
                          (!port_mode.master_mode && tx_shifting));

  // Register file next state
  always_comb begin
    ctl_next      = ctl_reg;
    seq_next      = seq_reg;
    rx_buf_next   = rx_buf_reg;
    buf_full_next = buf_full_reg;
    tx_data_next  = tx_data_reg;
    tx_load_next  = 1'b0;
    if (ctl_wr) begin
      ctl_next.port_enable   = w_data_reg[5];
      ctl_next.clock_release = w_data_reg[4];
      ctl_next.mode_select   = w_data_reg[3:0];
      // Software may only clear the flags; writing one leaves them alone
      if (!w_data_reg[WRITE_COLLISION_FLAG_BIT]) begin
        ctl_next.write_collision_flag = 1'b0;
      end
      if (!w_data_reg[OVF_BIT]) begin
        ctl_next.receive_overflow_flag = 1'b0;
      end
    end
    // Hardware set wins over a same-cycle software clear
    if (collision_hit) begin
      ctl_next.write_collision_flag = 1'b1;
    end
    if (overflow_hit) begin
      ctl_next.receive_overflow_flag = 1'b1;
    end
    if (seq_wr) begin
      seq_next = w_data_reg[SEQ_W-1:0];
    end
    seq_next = seq_next & ~seq_done;
    if (buf_rd) begin
      buf_full_next = 1'b0;
    end
    // The held byte is only replaced once software has taken it
    if (fifo_pop) begin
      rx_buf_next   = fifo_mem[rd_ptr_reg];
      buf_full_next = 1'b1;
    end
    if (buf_wr && port_mode.transmit_mode && !collision_hit) begin
      tx_data_next = w_data_reg[DATA_W-1:0];
      tx_load_next = 1'b1;
    end
    active_next = tx_in_progress | (|seq_next);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg      <= CTL_RESET;
      seq_reg      <= SEQ_RESET;
      active_reg   <= 1'b0;
      rx_buf_reg   <= BYTE_ZERO;
      buf_full_reg <= 1'b0;
      tx_data_reg  <= BYTE_ZERO;
      tx_load_reg  <= 1'b0;
    end else begin
      ctl_reg      <= ctl_next;
      seq_reg      <= seq_next;
      active_reg   <= active_next;
      rx_buf_reg   <= rx_buf_next;
      buf_full_reg <= buf_full_next;
      tx_data_reg  <= tx_data_next;
      tx_load_reg  <= tx_load_next;
    end
  end

  // Receive queue next state; ready drops when full so the sequencer stalls
  always_comb begin
    wr_ptr_next = fifo_push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = fifo_pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
    count_next  = count_reg;
    if (fifo_push && !fifo_pop) begin
      count_next = count_reg + CNT_ONE;
    end else if (fifo_pop && !fifo_push) begin
      count_next = count_reg - CNT_ONE;
    end
    rx_ready_next = (count_next != FIFO_FULL_CNT);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      rx_ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg   <= wr_ptr_next;
      rd_ptr_reg   <= rd_ptr_next;
      count_reg    <= count_next;
      rx_ready_reg <= rx_ready_next;
    end
  end

  // Queue storage needs no reset; entries are read only after being written
  always_ff @(posedge aclk) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr_reg] <= fifo_wdata;
    end
  end

  // Outputs straight from flops
  assign awready     = awready_reg;
  assign wready      = wready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign arready     = arready_reg;
  assign rvalid      = rvalid_reg;
  assign rresp       = rresp_reg;
  assign rdata       = rdata_reg;
  assign rx_ready    = rx_ready_reg;
  assign tx_data     = tx_data_reg;
  assign tx_load     = tx_load_reg;
  assign ctl_out     = ctl_reg;
  assign seq_enable  = seq_reg;
  assign port_active = active_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  active_status_a: assert property (
    port_active == ($past(tx_in_progress) | (|seq_reg)))
    else $error("active status does not follow its sources");

  master_collision_a: assert property (
    buf_wr && port_mode.transmit_mode && port_mode.master_mode && !start_allowed
    |=> ctl_reg.write_collision_flag && !tx_load_reg)
    else $error("master collision not flagged");

  slave_collision_a: assert property (
    buf_wr && port_mode.transmit_mode && !port_mode.master_mode && tx_shifting
    |=> ctl_reg.write_collision_flag && !tx_load_reg)
    else $error("slave collision not flagged");

  collision_hold_a: assert property (
    ctl_reg.write_collision_flag && !(ctl_wr && !w_data_reg[WRITE_COLLISION_FLAG_BIT])
    |=> ctl_reg.write_collision_flag)
    else $error("write collision cleared without software");

  overflow_set_a: assert property (
    rx_fire && !port_mode.transmit_mode && buf_full_reg && !buf_rd
    |=> ctl_reg.receive_overflow_flag ##1 ctl_reg.receive_overflow_flag || $past(ctl_wr))
    else $error("receive overflow not flagged");

  overflow_tx_a: assert property (
    port_mode.transmit_mode |=> !$rose(ctl_reg.receive_overflow_flag))
    else $error("overflow raised while transmitting");

  overflow_keep_a: assert property (
    overflow_hit && !buf_rd |=> $stable(rx_buf_reg) && buf_full_reg)
    else $error("unread byte replaced on overflow");

  write_resp_a: assert property (
    bvalid_reg |=> (bvalid_reg && $stable(bresp_reg)) || ($past(bready) && !bvalid_reg))
    else $error("write response not held");

endmodule

/* File: ipc_pkg.sv */
// Constants, field layouts and carrier types for the serial port control and error flag block.
// Assumes an AXI4-Lite master with 32-bit data and a same-clock shift and bus sequencer.
// How it works
// - Port active while transmitting or any sequence enabled
// - Buffer write at bad moment sets write collision
// - Byte arriving into full buffer sets receive overflow
// - Receive overflow ignored while port is transmitting
package ipc_pkg;

  // Register byte offsets
  localparam int               ADDR_W       = 8;
  localparam logic [ADDR_W-1:0] OFF_CTL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SEQ     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_BUF     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STAT    = 8'h0c;

  // Control register one, fields from bit 7 down to bit 0
  localparam int               WRITE_COLLISION_FLAG_BIT     = 7;
  localparam int               OVF_BIT      = 6;
  localparam logic [7:0]       CTL_RESET    = 8'h00;

  // Sequence enable register fields
  localparam int               SEQ_W        = 5;
  localparam int               SEQ_START    = 0;
  localparam int               SEQ_RSTART   = 1;
  localparam int               SEQ_STOP     = 2;
  localparam int               SEQ_RCV      = 3;
  localparam int               SEQ_ACK      = 4;
  localparam logic [SEQ_W-1:0] SEQ_RESET    = 5'h00;

  // Status register fields
  localparam int               STAT_ACTIVE  = 0;
  localparam int               STAT_FULL    = 1;

  // Bus answers and the zero byte
  localparam logic [1:0]       RESP_OKAY    = 2'h0;
  localparam logic [1:0]       RESP_SLVERR  = 2'h2;
  localparam logic [7:0]       BYTE_ZERO    = 8'h00;

  // Control register one as software sees it
  typedef struct packed {
    logic       write_collision_flag;
    logic       receive_overflow_flag;
    logic       port_enable;
    logic       clock_release;
    logic [3:0] mode_select;
  } ipc_ctl_s;

  // Mode of the port as the sequencer reports it
  typedef struct packed {
    logic master_mode;
    logic transmit_mode;
  } ipc_mode_s;

endpackage

/* File: ipc_seq_model.sv */
// Far-side model: the shift and bus sequencer feeding received bytes and ending sequences.
// Assumes the same aclk as the block; the bench queues bytes through push.
`timescale 1ns/1ps

module ipc_seq_model #(
  parameter int DLY = 8
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [ipc_pkg::SEQ_W-1:0] seq_enable,
  output logic [ipc_pkg::SEQ_W-1:0]      seq_done,
  output logic [7:0]                     rx_data,
  output logic                           rx_valid,
  input  wire logic                      rx_ready
);
  import ipc_pkg::*;
  logic [7:0] q[$];
  int         cnt;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  // A sequence ends DLY+1 cycles after an enable shows, slow enough to see active
  always @(posedge aclk) begin
    seq_done <= '0;
    if (!aresetn || seq_enable == '0 || seq_done != '0) begin
      cnt <= 0;
    end else if (cnt == DLY) begin
      seq_done <= seq_enable;
      cnt      <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Byte held until taken; an idle data line toggles so stale bytes never match
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      if (rx_valid && rx_ready) void'(q.pop_front());
      if (q.size() > 0) begin
        rx_valid <= 1'b1;
        rx_data  <= q[0];
      end else begin
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
      end
    end
  end
endmodule

/* File: ipc_port_flags_tb.sv */
// Self-checking bench for the control register flags, active status and transfer buffer.
// Assumes the sequencer model stands on the far side; the bench drives the mode levels.
`timescale 1ns/1ps

module ipc_port_flags_tb;
  import ipc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [2:0]  prot = 3'h0;
  logic [3:0]  strb = 4'h1;
  logic        awready, wready, bvalid, arready, rvalid, rx_valid, rx_ready, tx_load, port_active;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  ipc_mode_s   mode = 2'b00;
  logic        tx_in_progress = 1'b0, start_allowed = 1'b1, tx_shifting = 1'b0;
  logic [4:0]  seq_done, seq_enable;
  logic [7:0]  rx_data, tx_data;
  ipc_ctl_s    ctl_out;
  int          errors = 0, check_count = 0, cycles = 0, loads = 0, i, n;

  ipc_port_flags uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(prot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .port_mode(mode), .tx_in_progress(tx_in_progress),
    .start_allowed(start_allowed), .tx_shifting(tx_shifting), .seq_done(seq_done),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_load(tx_load), .ctl_out(ctl_out), .seq_enable(seq_enable), .port_active(port_active));

  ipc_seq_model #(.DLY(8)) model (.aclk(aclk), .aresetn(aresetn), .seq_enable(seq_enable),
    .seq_done(seq_done), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

  // 50 MHz clock
  initial begin
    forever #10 aclk = ~aclk;
  end

  // Hang guard and transmit load counter
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (tx_load === 1'b1) loads <= loads + 1;
    if (cycles == 8000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // AXI4-Lite write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    awaddr  <= a;
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and an unmapped place
    rd(OFF_CTL, d, r); chk(d, {24'h0, CTL_RESET});
    rd(OFF_SEQ, d, r); chk(d, {27'h0, SEQ_RESET});
    rd(8'h10, d, r); chk({30'h0, r}, {30'h0, RESP_SLVERR}); chk(d, 32'h0);
    wr(8'h10, 8'hff, r); chk({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    // Every sequence enable alone makes the port active until its sequence ends
    for (i = 0; i < SEQ_W; i++) begin
      wr(OFF_SEQ, 8'h01 << i, r);
      chk({31'h0, port_active}, 32'h1);
      chk({27'h0, seq_enable}, 32'h1 << i);
      n = 0;
      while (port_active !== 1'b0 && n < 40) begin
        @(posedge aclk);
        n++;
      end
      chk({31'h0, port_active}, 32'h0);
    end
    tx_in_progress <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({31'h0, port_active}, 32'h1);
    tx_in_progress <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(OFF_STAT, d, r); chk({31'h0, d[STAT_ACTIVE]}, 32'h0);
    $display("test active done");
    // Master transmit with the bus not ready, then a clean load, then slave busy
    mode <= 2'b11;
    start_allowed <= 1'b0;
    wr(OFF_BUF, 8'h5a, r);
    rd(OFF_CTL, d, r); chk({31'h0, d[WRITE_COLLISION_FLAG_BIT]}, 32'h1);
    chk({31'h0, ctl_out.write_collision_flag}, 32'h1);
    repeat (30) @(posedge aclk);
    // A write with byte lane 0 off must not clear the flag
    strb <= 4'h0;
    wr(OFF_CTL, 8'h00, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(OFF_CTL, d, r); chk({31'h0, d[WRITE_COLLISION_FLAG_BIT]}, 32'h1);
    strb <= 4'h1;
    wr(OFF_CTL, 8'h80, r);
    rd(OFF_CTL, d, r); chk({31'h0, d[WRITE_COLLISION_FLAG_BIT]}, 32'h1);
    wr(OFF_CTL, 8'h00, r);
    rd(OFF_CTL, d, r); chk({31'h0, d[WRITE_COLLISION_FLAG_BIT]}, 32'h0);
    start_allowed <= 1'b1;
    wr(OFF_BUF, 8'ha5, r);
    chk({24'h0, tx_data}, 32'ha5);
    rd(OFF_CTL, d, r); chk({31'h0, d[WRITE_COLLISION_FLAG_BIT]}, 32'h0);
    mode <= 2'b01;
    tx_shifting <= 1'b1;
    wr(OFF_BUF, 8'h3c, r);
    rd(OFF_CTL, d, r); chk({31'h0, d[WRITE_COLLISION_FLAG_BIT]}, 32'h1);
    chk(loads, 32'h1);
    tx_shifting <= 1'b0;
    wr(OFF_CTL, 8'h00, r);
    $display("test collision done");
    // Bytes arriving while transmitting raise no overflow
    model.push(8'h11);
    model.push(8'h22);
    repeat (10) @(posedge aclk);
    rd(OFF_CTL, d, r); chk({31'h0, d[OVF_BIT]}, 32'h0);
    // Master receive: buffer writes ignored; the second byte waits in the queue
    // while the first moves into the buffer, so only the third one overflows
    mode <= 2'b10;
    repeat (2) @(posedge aclk);
    wr(OFF_BUF, 8'h77, r);
    chk(loads, 32'h1);
    model.push(8'h33);
    model.push(8'h44);
    model.push(8'h55);
    repeat (30) @(posedge aclk);
    rd(OFF_CTL, d, r); chk({31'h0, d[OVF_BIT]}, 32'h1);
    rd(OFF_STAT, d, r); chk({31'h0, d[STAT_FULL]}, 32'h1);
    rd(OFF_BUF, d, r); chk(d, 32'h33);
    rd(OFF_STAT, d, r); chk({31'h0, d[STAT_FULL]}, 32'h1);
    rd(OFF_BUF, d, r); chk(d, 32'h44);
    rd(OFF_STAT, d, r); chk({31'h0, d[STAT_FULL]}, 32'h0);
    rd(OFF_CTL, d, r); chk({31'h0, d[OVF_BIT]}, 32'h1);
    wr(OFF_CTL, 8'h00, r);
    rd(OFF_CTL, d, r); chk({31'h0, d[OVF_BIT]}, 32'h0);
    $display("test overflow done");
    // Reset in mid-run clears a raised flag and a pending sequence
    mode <= 2'b11;
    start_allowed <= 1'b0;
    wr(OFF_BUF, 8'h69, r);
    wr(OFF_SEQ, 8'h01, r);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_CTL, d, r); chk(d, {24'h0, CTL_RESET});
    chk({27'h0, seq_enable}, {27'h0, SEQ_RESET});
    chk({31'h0, port_active}, 32'h0);
    $display("test reset again done");
    finish_test();
  end
endmodule
